// ==== inc/iqrx_pkg.sv ====
package iqrx_pkg;
  // Command word layout, bit positions within the ten-bit control word
  localparam int CMD_WIDTH = 10;
  localparam int BIT_SAMPLE_RATE = 0;
  localparam int BIT_FILTER_RESPONSE = 1;
  localparam int BIT_INPUT_PAIR = 2;
  localparam int BIT_CAL_MODE = 3;
  localparam int BIT_RX_POWER = 4;
  localparam int BIT_THIRD_AUX_POWER = 5;
  localparam int BIT_SECOND_AUX_POWER = 6;
  localparam int BIT_FIRST_AUX_POWER = 7;
  localparam int BIT_SERIAL_HIZ = 8;
  localparam int BIT_UNUSED = 9;
  localparam logic [9:0] CMD_RESET = 10'h000;

  // Sample and word widths
  localparam int SAMPLE_WIDTH = 15;
  localparam int OFFSET_WIDTH = 10;
  localparam int WORD_WIDTH = 16;
  localparam int OFFSET_SHIFT = 2;
  localparam logic [9:0] OFFSET_RESET = 10'h000;
  localparam logic FLAG_INPHASE = 1'b1;
  localparam logic FLAG_QUADRATURE = 1'b0;

  // Master clock divisions
  localparam int PHASE_WIDTH = 3;
  localparam logic [2:0] AFE_STROBE_PHASE = 3'h3;
  localparam logic [2:0] FILTER_STROBE_PHASE = 3'h7;
  localparam int RATE_WIDTH = 7;
  localparam logic [6:0] LOW_RATE_LAST = 7'h7f;
  localparam logic [6:0] HIGH_RATE_LAST = 7'h3f;

  // Calibration and settling
  localparam int CAL_CONVERSIONS = 16;
  localparam int CAL_COUNT_WIDTH = 4;
  localparam logic [3:0] CAL_LAST = 4'hf;
  localparam int FILTER_TAPS = 256;
  localparam int FILTER_DIVIDE = 8;
  localparam int SETTLE_CYCLES = FILTER_TAPS * FILTER_DIVIDE;
  localparam int SETTLE_WIDTH = 11;
  localparam logic [10:0] SETTLE_LAST = 11'(SETTLE_CYCLES - 1);

  // Serial output
  localparam int BIT_COUNT_WIDTH = 4;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    IQRX_SLEEP,
    IQRX_CALIBRATE,
    IQRX_SETTLE,
    IQRX_RUN,
    IQRX_DRAIN
  } iqrx_state_t;
endpackage

// ==== design/iqrx_fifo.sv ====
`timescale 1ns/1ps
module iqrx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop_mem;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // Output register is refilled whenever memory holds a word and the register is empty or being taken
  assign pop_mem = (count != '0) && (!out_valid || out_ready);
  assign empty = (count == '0) && !out_valid;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop_mem) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop_mem);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop_mem) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ==== design/iqrx_control.sv ====
`timescale 1ns/1ps
module iqrx_control (
  input wire logic clock,
  input wire logic resetn,
  input wire logic command_write,
  input wire logic [9:0] command_data,
  input wire logic offset_inphase_write,
  input wire logic offset_quadrature_write,
  input wire logic [9:0] offset_data,
  input wire logic [14:0] conv_inphase,
  input wire logic [14:0] conv_quadrature,
  input wire logic serial_ready,
  output logic sample_rate_select,
  output logic filter_response_select,
  output logic input_pair_select,
  output logic input_short,
  output logic converter_sleep,
  output logic afe_sample_strobe,
  output logic filter_strobe,
  output logic third_aux_converter_power,
  output logic second_aux_converter_power,
  output logic first_aux_converter_power,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic serial_sync_out,
  output logic serial_sync_oe,
  output logic samples_enabled,
  output logic sample_overrun,
  output logic [9:0] offset_inphase,
  output logic [9:0] offset_quadrature
);
  logic [9:0] receive_mode_control;
  iqrx_pkg::iqrx_state_t state;
  iqrx_pkg::iqrx_state_t next_state;
  logic [2:0] phase;
  logic [6:0] rate_count;
  logic sample_point;
  logic [3:0] cal_count;
  logic signed [18:0] cal_sum_i;
  logic signed [18:0] cal_sum_q;
  logic cal_done;
  logic [10:0] settle_count;
  logic settle_done;
  logic [14:0] pend_i;
  logic [14:0] pend_q;
  logic pend_i_valid;
  logic pend_q_valid;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [15:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;
  logic fifo_empty;
  logic [15:0] shift_word;
  logic [3:0] bit_count;
  logic shifting;
  logic pipeline_idle;
  logic power_on;

  // Clamp a wide signed value into a narrower signed range
  function automatic logic [14:0] sat15(input logic signed [16:0] v);
    if (v > 17'sd16383) begin
      sat15 = 15'h3fff;
    end else if (v < -17'sd16384) begin
      sat15 = 15'h4000;
    end else begin
      sat15 = v[14:0];
    end
  endfunction

  // Ten-bit offset counts in steps of four sample LSBs, hence the two-bit shift
  function automatic logic [14:0] apply_offset(input logic [14:0] s, input logic [9:0] off);
    logic signed [16:0] wide_s;
    logic signed [16:0] wide_off;
    wide_s = 17'(signed'(s));
    wide_off = 17'(signed'(off)) <<< iqrx_pkg::OFFSET_SHIFT;
    apply_offset = sat15(wide_s - wide_off);
  endfunction

  // Averaged offset mapped back down to ten bits, saturating
  function automatic logic [9:0] cal_offset(input logic signed [18:0] sum);
    logic signed [18:0] avg;
    avg = sum >>> (iqrx_pkg::CAL_COUNT_WIDTH + iqrx_pkg::OFFSET_SHIFT);
    if (avg > 19'sd511) begin
      cal_offset = 10'h1ff;
    end else if (avg < -19'sd512) begin
      cal_offset = 10'h200;
    end else begin
      cal_offset = avg[9:0];
    end
  endfunction

  // Command register, write only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      receive_mode_control <= iqrx_pkg::CMD_RESET;
    end else if (command_write) begin
      receive_mode_control <= command_data;
    end
  end

  assign sample_rate_select = receive_mode_control[iqrx_pkg::BIT_SAMPLE_RATE];
  assign filter_response_select =
    receive_mode_control[iqrx_pkg::BIT_FILTER_RESPONSE];
  assign input_pair_select = receive_mode_control[iqrx_pkg::BIT_INPUT_PAIR];
  assign third_aux_converter_power =
    receive_mode_control[iqrx_pkg::BIT_THIRD_AUX_POWER];
  assign second_aux_converter_power =
    receive_mode_control[iqrx_pkg::BIT_SECOND_AUX_POWER];
  assign first_aux_converter_power =
    receive_mode_control[iqrx_pkg::BIT_FIRST_AUX_POWER];
  assign power_on = receive_mode_control[iqrx_pkg::BIT_RX_POWER];

  // Master clock dividers; stopped while asleep to save power
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase <= '0;
    end else if (converter_sleep) begin
      phase <= '0;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  assign afe_sample_strobe = !converter_sleep && (phase[1:0] == iqrx_pkg::AFE_STROBE_PHASE[1:0]);
  assign filter_strobe = !converter_sleep && (phase == iqrx_pkg::FILTER_STROBE_PHASE);

  // Output sample rate counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rate_count <= '0;
    end else if (state != iqrx_pkg::IQRX_RUN || sample_point) begin
      rate_count <= '0;
    end else begin
      rate_count <= rate_count + 7'h01;
    end
  end

  assign sample_point = (state == iqrx_pkg::IQRX_RUN) &&
    (rate_count == (sample_rate_select ? iqrx_pkg::HIGH_RATE_LAST
                                       : iqrx_pkg::LOW_RATE_LAST));

  // Receive power sequencing
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= iqrx_pkg::IQRX_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      iqrx_pkg::IQRX_SLEEP: begin
        if (power_on) begin
          if (!receive_mode_control[iqrx_pkg::BIT_CAL_MODE]) begin
            next_state = iqrx_pkg::IQRX_CALIBRATE;
          end else begin
            next_state = iqrx_pkg::IQRX_SETTLE;
          end
        end
      end
      iqrx_pkg::IQRX_CALIBRATE: begin
        if (!power_on) begin
          next_state = iqrx_pkg::IQRX_SLEEP;
        end else if (cal_done) begin
          next_state = iqrx_pkg::IQRX_SETTLE;
        end
      end
      iqrx_pkg::IQRX_SETTLE: begin
        if (!power_on) begin
          next_state = iqrx_pkg::IQRX_SLEEP;
        end else if (settle_done) begin
          next_state = iqrx_pkg::IQRX_RUN;
        end
      end
      iqrx_pkg::IQRX_RUN: begin
        if (!power_on) begin
          next_state = iqrx_pkg::IQRX_DRAIN;
        end
      end
      iqrx_pkg::IQRX_DRAIN: begin
        if (pipeline_idle) begin
          next_state = iqrx_pkg::IQRX_SLEEP;
        end
      end
      default: begin
        next_state = iqrx_pkg::IQRX_SLEEP;
      end
    endcase
  end

  assign converter_sleep = (state == iqrx_pkg::IQRX_SLEEP);
  assign input_short = (state == iqrx_pkg::IQRX_CALIBRATE);
  assign samples_enabled = (state == iqrx_pkg::IQRX_RUN);
  assign pipeline_idle = !pend_i_valid && !pend_q_valid && fifo_empty && !shifting;

  // Offset measurement over shorted inputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cal_count <= '0;
      cal_sum_i <= '0;
      cal_sum_q <= '0;
    end else if (state != iqrx_pkg::IQRX_CALIBRATE) begin
      cal_count <= '0;
      cal_sum_i <= '0;
      cal_sum_q <= '0;
    end else if (filter_strobe) begin
      cal_count <= cal_count + 4'h1;
      cal_sum_i <= cal_sum_i + 19'(signed'(conv_inphase));
      cal_sum_q <= cal_sum_q + 19'(signed'(conv_quadrature));
    end
  end

  assign cal_done = filter_strobe && (cal_count == iqrx_pkg::CAL_LAST);

  // Offset registers; the last conversion joins the sum as it is loaded
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      offset_inphase <= iqrx_pkg::OFFSET_RESET;
      offset_quadrature <= iqrx_pkg::OFFSET_RESET;
    end else if (state == iqrx_pkg::IQRX_CALIBRATE && cal_done) begin
      offset_inphase <= cal_offset(cal_sum_i + 19'(signed'(conv_inphase)));
      offset_quadrature <= cal_offset(cal_sum_q + 19'(signed'(conv_quadrature)));
    end else begin
      if (offset_inphase_write) begin
        offset_inphase <= offset_data;
      end
      if (offset_quadrature_write) begin
        offset_quadrature <= offset_data;
      end
    end
  end

  // Filter settling after wake-up or calibration
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_count <= '0;
    end else if (state != iqrx_pkg::IQRX_SETTLE) begin
      settle_count <= '0;
    end else if (!settle_done) begin
      settle_count <= settle_count + 11'h001;
    end
  end

  assign settle_done = (settle_count == iqrx_pkg::SETTLE_LAST);

  // Sample capture; a new pair arriving while one is still pending is lost
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_i <= '0;
      pend_q <= '0;
      pend_i_valid <= 1'b0;
      pend_q_valid <= 1'b0;
    end else if (sample_point && !pend_i_valid && !pend_q_valid) begin
      pend_i <= apply_offset(conv_inphase, offset_inphase);
      pend_q <= apply_offset(conv_quadrature, offset_quadrature);
      pend_i_valid <= 1'b1;
      pend_q_valid <= 1'b1;
    end else if (fifo_in_ready) begin
      if (pend_i_valid) begin
        pend_i_valid <= 1'b0;
      end else if (pend_q_valid) begin
        pend_q_valid <= 1'b0;
      end
    end
  end

  // Set wins over the clear made by a command write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sample_overrun <= 1'b0;
    end else if (sample_point && (pend_i_valid || pend_q_valid)) begin
      sample_overrun <= 1'b1;
    end else if (command_write) begin
      sample_overrun <= 1'b0;
    end
  end

  // I word always goes ahead of its Q partner
  assign fifo_in_valid = pend_i_valid || pend_q_valid;
  assign fifo_in_data = pend_i_valid ? {pend_i, iqrx_pkg::FLAG_INPHASE}
                                     : {pend_q, iqrx_pkg::FLAG_QUADRATURE};

  iqrx_fifo #(
    .WIDTH(iqrx_pkg::WORD_WIDTH),
    .DEPTH(iqrx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .empty(fifo_empty)
  );

  // Serialiser waits on the processor, which is what backs the FIFO up
  assign fifo_out_ready = !shifting && serial_ready;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_word <= '0;
      bit_count <= '0;
      shifting <= 1'b0;
    end else if (!shifting) begin
      if (fifo_out_valid && serial_ready) begin
        shift_word <= fifo_out_data;
        bit_count <= '0;
        shifting <= 1'b1;
      end
    end else begin
      shift_word <= {shift_word[14:0], 1'b0};
      bit_count <= bit_count + 4'h1;
      if (bit_count == iqrx_pkg::BIT_LAST) begin
        shifting <= 1'b0;
      end
    end
  end

  // MSB first, sync marks the first bit of every word
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_data_out <= 1'b0;
      serial_sync_out <= 1'b0;
    end else begin
      serial_data_out <= shifting ? shift_word[15] : 1'b0;
      serial_sync_out <= shifting && (bit_count == '0);
    end
  end

  assign serial_data_oe = !receive_mode_control[iqrx_pkg::BIT_SERIAL_HIZ];
  assign serial_sync_oe = !receive_mode_control[iqrx_pkg::BIT_SERIAL_HIZ];
endmodule

// ==== tb/iqrx_props.sv ====
`timescale 1ns/1ps
module iqrx_props (
  input wire logic clock,
  input wire logic resetn,
  input wire logic command_write,
  input wire logic [9:0] command_data,
  input wire logic offset_inphase_write,
  input wire logic [9:0] offset_data,
  input wire logic input_short,
  input wire logic converter_sleep,
  input wire logic afe_sample_strobe,
  input wire logic filter_strobe,
  input wire logic sample_rate_select,
  input wire logic filter_response_select,
  input wire logic input_pair_select,
  input wire logic third_aux_converter_power,
  input wire logic second_aux_converter_power,
  input wire logic first_aux_converter_power,
  input wire logic serial_data_oe,
  input wire logic serial_sync_out,
  input wire logic samples_enabled,
  input wire logic [9:0] offset_inphase
);
  logic [11:0] awake_count;
  // Awake time, saturating; first sample may not come before settling
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awake_count <= '0;
    end else if (converter_sleep) begin
      awake_count <= '0;
    end else if (awake_count != 12'hfff) begin
      awake_count <= awake_count + 12'h001;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_word_gap;
    !serial_sync_out [*8] ##1 !serial_sync_out [*7];
  endsequence
  property p_afe;
    afe_sample_strobe |=> !afe_sample_strobe [*3];
  endproperty
  property p_filt;
    filter_strobe |=> !filter_strobe [*7];
  endproperty
  property p_cmd;
    command_write |=> {input_pair_select, filter_response_select, sample_rate_select}
      == $past(command_data[2:0]);
  endproperty
  property p_aux;
    command_write |=> {first_aux_converter_power, second_aux_converter_power,
      third_aux_converter_power} == $past(command_data[7:5]);
  endproperty
  property p_hiz;
    command_write |=> serial_data_oe != $past(command_data[8]);
  endproperty
  property p_sleep;
    converter_sleep |-> !samples_enabled && !afe_sample_strobe && !filter_strobe;
  endproperty
  property p_short;
    input_short |-> !samples_enabled;
  endproperty
  property p_sync;
    serial_sync_out |=> s_word_gap;
  endproperty
  property p_off;
    offset_inphase_write && !input_short |=> offset_inphase == $past(offset_data);
  endproperty
  a_afe: assert property (p_afe) else $error("afe strobe spacing");
  a_filt: assert property (p_filt) else $error("filter strobe spacing");
  a_cmd: assert property (p_cmd) else $error("select decode");
  a_aux: assert property (p_aux) else $error("aux power decode");
  a_hiz: assert property (p_hiz) else $error("serial enable");
  a_sleep: assert property (p_sleep) else $error("activity in sleep");
  a_short: assert property (p_short) else $error("samples during cal");
  a_sync: assert property (p_sync) else $error("word too short");
  a_off: assert property (p_off) else $error("offset write lost");
  property p_settle;
    $rose(samples_enabled) |-> awake_count >= 12'(iqrx_pkg::SETTLE_CYCLES);
  endproperty
  a_settle: assert property (p_settle) else $error("samples before settling");
endmodule

bind iqrx_control iqrx_props u_props (.*);

// ==== tb/iqrx_dsp_model.sv ====
`timescale 1ns/1ps
module iqrx_dsp_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic serial_data_out,
  input wire logic serial_sync_out,
  input wire logic serial_data_oe,
  input wire logic stall,
  output logic serial_ready,
  output logic [15:0] last_i,
  output logic [15:0] last_q,
  output int i_count,
  output int q_count,
  output int i_start,
  output int i_prev
);
  logic [14:0] shift;
  logic line_d;
  int bit_n;
  int cycle;
  // Stalls only on request; a real port would also stall between bursts
  assign serial_ready = !stall;
  // Undriven line shows the inverse, so a floating output cannot pass
  assign line_d = serial_data_oe ? serial_data_out : !serial_data_out;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_n <= 0;
      cycle <= 0;
      i_count <= 0;
      q_count <= 0;
    end else begin
      cycle <= cycle + 1;
      if (serial_sync_out && serial_data_oe) begin
        shift <= {14'h0000, line_d};
        bit_n <= 1;
      end else if (bit_n > 0 && bit_n < 15) begin
        shift <= {shift[13:0], line_d};
        bit_n <= bit_n + 1;
      end else if (bit_n == 15) begin
        bit_n <= 0;
        if (line_d) begin
          last_i <= {shift, 1'b1};
          i_count <= i_count + 1;
          i_prev <= i_start;
          i_start <= cycle;
        end else begin
          last_q <= {shift, 1'b0};
          q_count <= q_count + 1;
        end
      end
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic command_write = 1'b0;
  logic [9:0] command_data = 10'h000;
  logic offset_inphase_write = 1'b0;
  logic offset_quadrature_write = 1'b0;
  logic [9:0] offset_data = 10'h000;
  logic [14:0] conv_inphase = 15'h0100;
  logic [14:0] conv_quadrature = 15'h0100;
  logic stall = 1'b0;
  logic serial_ready, sample_rate_select, filter_response_select, input_pair_select;
  logic input_short, converter_sleep, afe_sample_strobe, filter_strobe, samples_enabled;
  logic third_aux_converter_power, second_aux_converter_power, first_aux_converter_power;
  logic serial_data_out, serial_data_oe, serial_sync_out, serial_sync_oe, sample_overrun;
  logic [9:0] offset_inphase, offset_quadrature;
  logic [15:0] last_i, last_q;
  logic seen_short = 1'b0;
  int i_count, q_count, i_start, i_prev;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  iqrx_control u_dut (.*);
  iqrx_dsp_model u_dsp (.*);
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (input_short === 1'b1) seen_short <= 1'b1;
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #2;
  endtask
  task automatic wr_cmd(input logic [9:0] d);
    step();
    command_write = 1'b1;
    command_data = d;
    step();
    command_write = 1'b0;
  endtask
  task automatic wr_off(input logic q, input logic [9:0] d);
    step();
    offset_inphase_write = !q;
    offset_quadrature_write = q;
    offset_data = d;
    step();
    offset_inphase_write = 1'b0;
    offset_quadrature_write = 1'b0;
  endtask
  task automatic wait_i(input int k);
    int t;
    t = i_count + k;
    for (int n = 0; n < 3000 && i_count < t; n++) step();
    chk("words", 1, i_count >= t);
  endtask
  task automatic wait_en(output int n);
    for (n = 0; n < 3000 && samples_enabled !== 1'b1; n++) step();
    chk("enabled", 1, samples_enabled);
  endtask
  task automatic t_reset();
    chk("sleep", 1, converter_sleep);
    chk("oe", 1, serial_data_oe & serial_sync_oe);
    chk("offs", 0, {6'h00, offset_inphase | offset_quadrature});
  endtask
  task automatic t_decode();
    logic [9:0] d;
    for (int b = 0; b < 10; b++) begin
      if (b == 4) continue;
      d = 10'h001 << b;
      wr_cmd(d);
      chk("decode", {8'h00, d[8], d[8:5], d[2:0]}, {8'h00, !serial_sync_oe, !serial_data_oe,
        first_aux_converter_power, second_aux_converter_power, third_aux_converter_power,
        input_pair_select, filter_response_select, sample_rate_select});
    end
    wr_cmd(10'h000);
  endtask
  task automatic t_user();
    int n;
    wr_off(1'b0, 10'h004);
    wr_off(1'b1, 10'h3fc);
    seen_short = 1'b0;
    wr_cmd(10'h019);
    wait_en(n);
    chk("settle", 1, n >= 2040);
    chk("cal", 0, seen_short);
    chk("off_i", 16'h0004, {6'h00, offset_inphase});
    chk("off_q", 16'h03fc, {6'h00, offset_quadrature});
    wait_i(2);
    chk("per_hi", 16'd64, 16'(i_start - i_prev));
    chk("word_i", 16'h01e1, last_i);
    chk("word_q", 16'h0220, last_q);
    wr_cmd(10'h018);
    wait_i(3);
    chk("per_lo", 16'd128, 16'(i_start - i_prev));
  endtask
  task automatic t_stall();
    wr_cmd(10'h019);
    stall = 1'b1;
    // Long enough to overflow FIFO plus output register at the high rate
    repeat (700) step();
    chk("overrun", 1, sample_overrun);
    stall = 1'b0;
    wait_i(10);
    chk("word_i", 16'h01e1, last_i);
    wr_cmd(10'h019);
    chk("overrun_clr", 0, sample_overrun);
  endtask
  task automatic t_drain();
    int n;
    wr_cmd(10'h000);
    for (n = 0; n < 2000 && converter_sleep !== 1'b1; n++) step();
    chk("drain", 1, converter_sleep);
    chk("pairs", 16'(i_count), 16'(q_count));
  endtask
  task automatic t_auto();
    int n;
    conv_inphase = 15'h0040;
    conv_quadrature = 15'h0040;
    wr_cmd(10'h010);
    // Power bit is seen one edge after the write lands
    step();
    chk("short", 1, input_short);
    for (n = 0; n < 400 && input_short === 1'b1; n++) step();
    chk("cal_len", 1, n > 120 && n <= 137);
    chk("cal_i", 16'h0010, {6'h00, offset_inphase});
    chk("cal_q", 16'h0010, {6'h00, offset_quadrature});
    wait_en(n);
    wait_i(2);
    chk("word_i", 16'h0001, last_i);
    chk("word_q", 16'h0000, last_q);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #2;
    resetn = 1'b1;
    t_reset();
    t_decode();
    t_user();
    t_stall();
    t_drain();
    t_auto();
    conclude();
  end
endmodule
